//--- src/pcs_core.sv
// Purpose: program counter, return stack and indirect addressing
// Assumes: execution logic issues one operation per cycle
// Notes: outputs registered; memory strobes flopped one cycle late
`timescale 1ns/10ps
module pcs_core (
  input wire logic I_REF_CLK,
  input wire logic I_RSTN,
  input wire logic [5:0] I_OP,
  input wire logic [7:0] I_LOW_WDATA,
  input wire logic [10:0] I_JUMP_ADDR,
  input wire logic [12:0] I_VECTOR,
  input wire logic I_LATCH_WR,
  input wire logic [7:0] I_LATCH_WDATA,
  input wire logic I_PTR_WR,
  input wire logic [7:0] I_PTR_WDATA,
  input wire logic I_BANK_BIT,
  input wire logic I_IND_RD,
  input wire logic I_IND_WR,
  input wire logic [7:0] I_IND_WDATA,
  input wire logic [7:0] I_MEM_RDATA,
  output logic [12:0] O_PC,
  output logic [7:0] O_PC_LOW,
  output logic [7:0] O_PC_LATCH,
  output logic [7:0] O_PTR,
  output logic [8:0] O_MEM_ADDR,
  output logic O_MEM_RD,
  output logic O_MEM_WR,
  output logic [7:0] O_MEM_WDATA,
  output logic [7:0] O_IND_RDATA
);
  logic [pcs_pkg::PC_W-1:0] pc_r; // program counter
  logic [pcs_pkg::PC_W-1:0] pc_nxt; // next pc
  logic [7:0] latch_r; // pc_high_latch
  logic [7:0] ptr_r; // file_select_pointer
  logic push; // stack push strobe
  logic pop; // stack pop strobe
  logic [pcs_pkg::PC_W-1:0] stack_top; // entry to return to
  logic [pcs_pkg::PC_W-1:0] push_data; // value pushed
  logic [pcs_pkg::DADDR_W-1:0] ind_addr; // indirect address
  logic ind_rd; // gated read
  logic ind_wr; // gated write
  logic [7:0] ind_rdata; // indirect read value
  logic [pcs_pkg::PC_W-1:0] pc_inc; // pc plus one

  assign pc_inc = pc_r + 13'h0001;

  // call pushes return address, the current pc plus one; no other op pushes
  assign push = (I_OP == pcs_pkg::PCS_OP_CALL);
  // covers return, return_with_literal, return_from_interrupt
  assign pop = (I_OP == pcs_pkg::PCS_OP_RET);
  assign push_data = pc_inc;

  // next pc select
  always_comb begin
    pc_nxt = pc_r;
    case (I_OP)
      pcs_pkg::PCS_OP_NONE: begin
        pc_nxt = pc_r;
      end
      pcs_pkg::PCS_OP_INC: begin
        pc_nxt = pc_inc;
      end
      pcs_pkg::PCS_OP_WRLOW: begin
        // latch 4:0 with new low byte, no carry from sum
        pc_nxt = {latch_r[pcs_pkg::UP_W-1:0], I_LOW_WDATA};
      end
      pcs_pkg::PCS_OP_JUMP, pcs_pkg::PCS_OP_CALL: begin
        // latch 4:3 then address field
        pc_nxt = {latch_r[4:pcs_pkg::LATCH_HI_POS], I_JUMP_ADDR};
      end
      pcs_pkg::PCS_OP_RET: begin
        // back to stacked address
        pc_nxt = stack_top;
      end
      default: begin
        // unknown op holds pc
        pc_nxt = pc_r;
      end
    endcase
  end

  // pc register; reset clears all 13 bits
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      pc_r <= pcs_pkg::PC_RST;
    end else begin
      pc_r <= pc_nxt;
    end
  end

  // latch written only by software, never by stack ops
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      latch_r <= 8'h00;
    end else if (I_LATCH_WR) begin
      latch_r <= I_LATCH_WDATA;
    end
  end

  // pointer register
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      ptr_r <= 8'h00;
    end else if (I_PTR_WR) begin
      ptr_r <= I_PTR_WDATA;
    end
  end

  // return stack
  pcs_ret_stack u_stack (
    .i_clk(I_REF_CLK),
    .i_rstn(I_RSTN),
    .i_push(push),
    .i_pop(pop),
    .i_data(push_data),
    .o_top(stack_top)
  );

  // indirect path from current pointer and bank bit
  pcs_indirect u_ind (
    .i_bank(I_BANK_BIT),
    .i_ptr(ptr_r),
    .i_rd(I_IND_RD),
    .i_wr(I_IND_WR),
    .i_mem_rdata(I_MEM_RDATA),
    .o_addr(ind_addr),
    .o_mem_rd(ind_rd),
    .o_mem_wr(ind_wr),
    .o_rdata(ind_rdata)
  );

  // registered outputs
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_PC <= pcs_pkg::PC_RST;
      O_PC_LOW <= 8'h00;
      O_PC_LATCH <= 8'h00;
      O_PTR <= 8'h00;
    end else begin
      O_PC <= pc_nxt;
      O_PC_LOW <= pc_nxt[pcs_pkg::LOW_W-1:0];
      O_PC_LATCH <= I_LATCH_WR ? I_LATCH_WDATA : latch_r;
      O_PTR <= I_PTR_WR ? I_PTR_WDATA : ptr_r;
    end
  end

  // memory strobes, one cycle after request
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_MEM_ADDR <= 9'h000;
      O_MEM_RD <= 1'b0;
      O_MEM_WR <= 1'b0;
      O_MEM_WDATA <= 8'h00;
      O_IND_RDATA <= 8'h00;
    end else begin
      O_MEM_ADDR <= ind_addr;
      O_MEM_RD <= ind_rd;
      O_MEM_WR <= ind_wr;
      O_MEM_WDATA <= I_IND_WDATA;
      O_IND_RDATA <= ind_rdata;
    end
  end
endmodule // pcs_core

//--- common/pcs_pkg.sv
// Purpose: shared constants for the program counter, stack and indirect path
// Assumes: single clock, 8-bit data, 13-bit program addresses
// Notes: pc, stack and indirect widths, pc and stack pointer reset values and op encodings live here
package pcs_pkg;
  localparam int PC_W = 13;          // program counter width
  localparam int LOW_W = 8;          // low byte width
  localparam int UP_W = 5;           // upper bit count
  localparam int JMP_W = 11;         // address field of call or jump
  localparam int DEPTH = 8;          // return stack levels
  localparam int SP_W = 3;           // stack pointer width
  localparam int DADDR_W = 9;        // indirect data address width
  localparam int LATCH_HI_POS = 3;   // latch bits used by call or jump
  localparam logic [PC_W-1:0] PC_RST = 13'h0000;      // pc after reset
  localparam logic [SP_W-1:0] SP_RST = 3'h0;          // pointer after reset
  localparam logic [7:0] PORT_ADDR = 8'h00;           // indirect port address
  localparam logic [7:0] ZERO_BYTE = 8'h00;           // read of port itself
  // pc operations issued by the execution logic
  typedef enum logic [5:0] {
    PCS_OP_NONE  = 6'h01,
    PCS_OP_INC   = 6'h02,
    PCS_OP_WRLOW = 6'h04,
    PCS_OP_JUMP  = 6'h08,
    PCS_OP_CALL  = 6'h10,
    PCS_OP_RET   = 6'h20
  } pcs_op_t;
endpackage

//--- src/pcs_ret_stack.sv
// Purpose: circular return stack of eight 13-bit entries
// Assumes: push and pop never asserted together
// Notes: pointer hidden; wraps silently both ways
`timescale 1ns/10ps
module pcs_ret_stack (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_push,
  input wire logic i_pop,
  input wire logic [pcs_pkg::PC_W-1:0] i_data,
  output logic [pcs_pkg::PC_W-1:0] o_top
);
  // storage, outside program and data space
  logic [pcs_pkg::PC_W-1:0] mem_r [pcs_pkg::DEPTH];
  logic [pcs_pkg::SP_W-1:0] sp_r; // next free slot
  logic [pcs_pkg::SP_W-1:0] sp_dec; // last written slot

  assign sp_dec = sp_r - 3'h1;
  assign o_top = mem_r[sp_dec];

  // pointer update, wraps with no flag
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sp_r <= pcs_pkg::SP_RST;
    end else if (i_push) begin
      sp_r <= sp_r + 3'h1;
    end else if (i_pop) begin
      sp_r <= sp_dec;
    end
  end

  // ninth push overwrites first slot
  always_ff @(posedge i_clk) begin
    if (i_push) begin
      mem_r[sp_r] <= i_data;
    end
  end
endmodule // pcs_ret_stack

//--- src/pcs_indirect.sv
// Purpose: indirect data access through the file select pointer
// Assumes: combinational path into data memory
// Notes: port address selects nothing real
`timescale 1ns/10ps
module pcs_indirect (
  input wire logic i_bank,
  input wire logic [7:0] i_ptr,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [7:0] i_mem_rdata,
  output logic [pcs_pkg::DADDR_W-1:0] o_addr,
  output logic o_mem_rd,
  output logic o_mem_wr,
  output logic [7:0] o_rdata
);
  logic self_sel; // pointer aims at the port itself

  assign self_sel = (i_ptr == pcs_pkg::PORT_ADDR);
  // bank bit on top of pointer
  assign o_addr = {i_bank, i_ptr};
  // access redirected to memory
  assign o_mem_rd = i_rd & ~self_sel;
  // write to itself stores nothing
  assign o_mem_wr = i_wr & ~self_sel;
  // self read gives zero
  assign o_rdata = self_sel ? pcs_pkg::ZERO_BYTE : i_mem_rdata;
endmodule // pcs_indirect

//--- tb/pcs_mem_model.sv
// Purpose: data memory seen by the indirect path
// Assumes: write strobe and address arrive registered
// Notes: unwritten places read unknown, no kindness
`timescale 1ns/10ps
module pcs_mem_model (
  input wire logic i_clk,
  input wire logic i_bank,
  input wire logic [7:0] i_ptr,
  input wire logic i_wr,
  input wire logic [8:0] i_waddr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata
);
  logic [7:0] mem_r [0:511]; // storage cells
  // store on the flopped strobe
  always_ff @(posedge i_clk) begin
    if (i_wr) begin
      mem_r[i_waddr] <= i_wdata;
    end
  end
  assign o_rdata = mem_r[{i_bank, i_ptr}];
endmodule // pcs_mem_model

//--- tb/pcs_core_checker.sv
// Purpose: port relations of the pc, stack and indirect path
// Assumes: one clock, async low reset
// Notes: sees top ports only
`timescale 1ns/10ps
module pcs_core_checker (
  input wire logic I_REF_CLK,
  input wire logic I_RSTN,
  input wire logic [5:0] I_OP,
  input wire logic [7:0] I_LOW_WDATA,
  input wire logic [10:0] I_JUMP_ADDR,
  input wire logic I_LATCH_WR,
  input wire logic I_BANK_BIT,
  input wire logic I_IND_RD,
  input wire logic I_IND_WR,
  input wire logic [7:0] I_MEM_RDATA,
  input wire logic [12:0] O_PC,
  input wire logic [7:0] O_PC_LOW,
  input wire logic [7:0] O_PC_LATCH,
  input wire logic [7:0] O_PTR,
  input wire logic [8:0] O_MEM_ADDR,
  input wire logic O_MEM_RD,
  input wire logic O_MEM_WR,
  input wire logic [7:0] O_IND_RDATA
);
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RSTN);
  // call followed at once by a return
  sequence call_ret_s;
    I_OP == 6'h10 ##1 I_OP == 6'h20;
  endsequence
  a_reset_pc_clear: assert property ($rose(I_RSTN) |->
    O_PC == 13'h0000)
    else $error("pc not clear after reset");
  a_low_byte_view: assert property (O_PC_LOW == O_PC[7:0])
    else $error("low byte differs from pc");
  a_low_write_load: assert property (I_OP == 6'h04 |=>
    O_PC == {$past(O_PC_LATCH[4:0]), $past(I_LOW_WDATA)})
    else $error("low byte write load wrong");
  a_jump_load: assert property (I_OP inside {6'h08, 6'h10} |=>
    O_PC == {$past(O_PC_LATCH[4:3]), $past(I_JUMP_ADDR)})
    else $error("call or jump load wrong");
  a_latch_kept: assert property (!I_LATCH_WR |=> $stable(O_PC_LATCH))
    else $error("latch moved without a write");
  a_call_return: assert property (call_ret_s |=>
    O_PC == $past(O_PC, 2) + 13'h1)
    else $error("return did not restore pc");
  a_ind_addr_form: assert property (
    (I_IND_RD || I_IND_WR) && O_PTR != 8'h00
    |=> O_MEM_ADDR == {$past(I_BANK_BIT), $past(O_PTR)})
    else $error("indirect address wrong");
  a_ind_read_data: assert property (I_IND_RD && O_PTR != 8'h00 |=>
    O_MEM_RD && O_IND_RDATA == $past(I_MEM_RDATA))
    else $error("indirect read wrong");
  a_self_read_zero: assert property (I_IND_RD && O_PTR == 8'h00 |=>
    !O_MEM_RD && O_IND_RDATA == 8'h00)
    else $error("self read not zero");
  a_self_write_none: assert property (
    I_IND_WR && O_PTR == 8'h00 |=> !O_MEM_WR)
    else $error("self write stored");
endmodule // pcs_core_checker
bind pcs_core pcs_core_checker chk_u (.*);

//--- tb/pcs_core_bench.sv
// Purpose: directed bench for pc, stack and indirect path
// Assumes: inputs change on the falling edge
// Notes: pc and stack modelled locally
`timescale 1ns/10ps
module pcs_core_bench;
  logic I_REF_CLK = 1'b0, I_RSTN = 1'b0, I_LATCH_WR = 1'b0, I_PTR_WR = 1'b0;
  logic I_BANK_BIT = 1'b0, I_IND_RD = 1'b0, I_IND_WR = 1'b0;
  logic [5:0] I_OP = 6'h01;
  logic [7:0] I_LOW_WDATA = 8'h00, I_LATCH_WDATA = 8'h00, I_PTR_WDATA = 8'h00;
  logic [7:0] I_IND_WDATA = 8'h00, I_MEM_RDATA, O_PC_LOW, O_PC_LATCH, O_PTR;
  logic [7:0] O_MEM_WDATA, O_IND_RDATA, lat_e = 8'h00;
  logic [10:0] I_JUMP_ADDR = 11'h000;
  logic [12:0] I_VECTOR = 13'h0000, O_PC, pc_e = 13'h0000;
  logic [12:0] stk [0:7]; // expected stack slots
  logic [8:0] O_MEM_ADDR;
  logic O_MEM_RD, O_MEM_WR;
  logic [2:0] sp = 3'h0; // expected hidden pointer
  int err_count = 0, check_count = 0;
  pcs_core dut_u (.*);
  pcs_mem_model mem_u (.i_clk(I_REF_CLK), .i_bank(I_BANK_BIT), .i_ptr(O_PTR),
    .i_wr(O_MEM_WR), .i_waddr(O_MEM_ADDR), .i_wdata(O_MEM_WDATA),
    .o_rdata(I_MEM_RDATA));
  initial begin
    forever #5 I_REF_CLK = ~I_REF_CLK;
  end
  task chk(input logic [12:0] s, input logic [12:0] e);
    check_count++;
    if (s !== e) begin
      err_count++;
      $display("Error at %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  // one cycle of op, then pc, low byte and latch compared
  task step(input logic [5:0] op);
    logic [12:0] nx;
    I_OP = op;
    nx = pc_e;
    case (op)
      6'h02: nx = pc_e + 13'h1;
      6'h04: nx = {lat_e[4:0], I_LOW_WDATA};
      6'h08: nx = {lat_e[4:3], I_JUMP_ADDR};
      6'h10: begin
        stk[sp] = pc_e + 13'h1;
        sp = sp + 3'h1;
        nx = {lat_e[4:3], I_JUMP_ADDR};
      end
      6'h20: begin
        sp = sp - 3'h1;
        nx = stk[sp];
      end
      default: nx = pc_e;
    endcase
    @(negedge I_REF_CLK);
    pc_e = nx;
    chk(O_PC, pc_e);
    chk(O_PC_LOW, pc_e[7:0]);
    chk(O_PC_LATCH, lat_e);
  endtask
  task wr_latch(input logic [7:0] d);
    I_LATCH_WR = 1'b1;
    I_LATCH_WDATA = d;
    lat_e = d;
    step(6'h01);
    I_LATCH_WR = 1'b0;
  endtask
  // pointer write, then one indirect request and its answer
  task ind(input logic [7:0] p, input logic b, input logic w,
           input logic [7:0] wd, input logic [7:0] e);
    I_PTR_WR = 1'b1;
    I_PTR_WDATA = p;
    step(6'h01);
    I_PTR_WR = 1'b0;
    I_BANK_BIT = b;
    I_IND_RD = !w;
    I_IND_WR = w;
    I_IND_WDATA = wd;
    step(6'h01);
    I_IND_RD = 1'b0;
    I_IND_WR = 1'b0;
    if (p != 8'h00) chk(O_MEM_ADDR, {b, p});
    chk(O_MEM_WR, w && p != 8'h00);
    chk(O_MEM_RD, !w && p != 8'h00);
    if (!w) chk(O_IND_RDATA, e);
  endtask
  task end_of_test;
    if (err_count == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge I_REF_CLK);
    @(negedge I_REF_CLK);
    I_RSTN = 1'b1;
    step(6'h01);
    wr_latch(8'hF5);
    I_LOW_WDATA = 8'hFF;
    step(6'h04);
    I_LOW_WDATA = 8'h00;
    step(6'h04);
    step(6'h02);
    I_JUMP_ADDR = 11'h7AB;
    step(6'h08);
    // nine calls wrap the stack, eight returns unwind it
    for (int i = 0; i < 9; i++) begin
      I_JUMP_ADDR = 11'(i * 16 + 3);
      step(6'h10);
    end
    for (int i = 0; i < 8; i++) step(6'h20);
    step(6'h10);
    step(6'h20);
    step(6'h01);
    ind(8'h20, 1'b1, 1'b1, 8'h3C, 8'h00);
    ind(8'h20, 1'b1, 1'b0, 8'h00, 8'h3C);
    ind(8'h00, 1'b0, 1'b0, 8'h00, 8'h00);
    ind(8'h00, 1'b0, 1'b1, 8'h99, 8'h00);
    I_RSTN = 1'b0;
    @(negedge I_REF_CLK);
    chk(O_PC, 13'h0000);
    end_of_test();
  end
endmodule // pcs_core_bench
